// file: rtl/sensor_cfg_defs.svh
// constants for the offset and gain configuration bank
// assumes word-aligned classic wishbone access, byte address = index * 4
`ifndef SENSOR_CFG_DEFS_SVH
`define SENSOR_CFG_DEFS_SVH

// register indices, byte address is four times the index
`define IDX_LANE_EN      8'h52
`define IDX_COL_BIAS     8'h54
`define IDX_COL_PRECH    8'h55
`define IDX_TG_LOW       8'h58
`define IDX_RST_LOW      8'h5b
`define IDX_PRECH_LVL    8'h5e
`define IDX_REF_LVL      8'h5f
`define IDX_RAMP_A       8'h62
`define IDX_RAMP_B       8'h63
`define IDX_OFFS_LO      8'h64
`define IDX_OFFS_HI      8'h65
`define IDX_AMP_GAIN     8'h66
`define IDX_SLOPE        8'h67
`define IDX_CFG_B        8'h73
`define IDX_CFG_A        8'h75
`define IDX_STATUS       8'h78
`define IDX_DARK_LVL     8'h79

// reset values
`define RST_LANE_EN      3'h0
`define RST_COL_BIAS     4'h0
`define RST_COL_PRECH    4'h0
`define RST_LEVEL7       7'h00
`define RST_RAMP         7'h60
`define RST_OFFSET       14'h3fc3
`define RST_AMP_GAIN     2'h0
`define RST_SLOPE        8'h20
`define RST_CFG          1'h0

// offset field split: low byte, then upper six bits
`define OFFS_LO_W        8
`define OFFS_HI_W        6

// status register fields
`define ST_CLIP_LO       0
`define ST_CLIP_HI       1
`define ST_RAMP_MISMATCH 2

// fixed converter offset in digital numbers
`define ADC_FIXED_OFFS   18'sh00046

`endif

// file: rtl/sensor_cfg_pkg.sv
// types shared by the offset and gain configuration bank
// assumes the constants header supplies offsets and reset values
package sensor_cfg_pkg;

    // column amplifier gain codes
    typedef enum logic [1:0] {
        GAIN_X1_0,
        GAIN_X1_2,
        GAIN_X1_4,
        GAIN_X1_6
    } amp_gain_e;

    // two's-complement dark level offset
    typedef logic signed [13:0] offset_t;

    // signed working width for the pixel sum
    typedef logic signed [17:0] pix_sum_t;

endpackage

// file: rtl/sensor_offset_gain_config.sv
// offset, gain and bias configuration bank with the dark level datapath
// assumes a classic wishbone master on clk_i and a pixel stream on clk_i
// assumes the host loads the required bias values; none are enforced here
// assumes ce_i freezes every register, while rst_i acts regardless of it
//
// Summary of operation
// RULE1 - offset field is 14-bit two's complement
// RULE2 - dark level equals 70 plus signed offset
// RULE3 - offset split over 100 and 101, reset 16323
// RULE4 - 2-bit column gain at 102, default zero
// RULE5 - 8-bit ramp slope at 103, default 32
// RULE6 - real converter gain depends on master clock
// RULE7 - host loads required values before imaging
// RULE8 - host writes listed required bias values
// RULE9 - host keeps ramp start levels 98, 99 equal
// RULE10 - host tunes slope and ramp within ranges
// RULE11 - host calibrates offset from dark frames
// RULE12 - host raises slope until saturation at 1023
// RULE13 - host matches sensors near grey 512
// RULE14 - offset sum clamps, never wraps
`timescale 1ns/100ps
`default_nettype none
`include "sensor_cfg_defs.svh"

module sensor_offset_gain_config
    import sensor_cfg_pkg::*;
#(
    parameter int PIX_W = 10                     // output code width
) (
    input  wire logic             clk_i,         // 50 MHz clock
    input  wire logic             rst_i,         // sync reset, high
    input  wire logic             ce_i,          // clock enable
    input  wire logic             cyc_i,         // wishbone cycle
    input  wire logic             stb_i,         // wishbone strobe
    input  wire logic             we_i,          // write enable
    input  wire logic [9:0]       adr_i,         // byte address
    input  wire logic [3:0]       sel_i,         // byte lanes
    input  wire logic [31:0]      dat_i,         // write data
    output logic      [31:0]      dat_o,         // read data
    output logic                  ack_o,         // acknowledge
    input  wire logic [PIX_W-1:0] pix_i,         // raw converter code
    input  wire logic             pix_valid_i,   // raw code valid
    output logic      [PIX_W-1:0] pix_o,         // offset-corrected code
    output logic                  pix_valid_o,   // corrected code valid
    output logic      [2:0]       lane_en_o,     // upper lane enables
    output logic      [3:0]       col_bias_o,    // column bias current
    output logic      [3:0]       col_prech_o,   // precharge current
    output logic      [6:0]       tg_low_o,      // transfer gate low
    output logic      [6:0]       rst_low_o,     // pixel reset low
    output logic      [6:0]       prech_lvl_o,   // precharge level
    output logic      [6:0]       ref_lvl_o,     // reference level
    output logic      [6:0]       ramp_a_o,      // ramp start level a
    output logic      [6:0]       ramp_b_o,      // ramp start level b
    output logic      [1:0]       amp_gain_o,    // column amp gain code
    output logic      [7:0]       slope_o,       // ramp slope setting
    output logic                  cfg_a_o,       // configuration bit a
    output logic                  cfg_b_o        // configuration bit b
);

    // largest code the output can carry
    localparam pix_sum_t PIX_MAX = pix_sum_t'((1 << PIX_W) - 1);

    // register storage
    logic [2:0]  lane_en_q;
    logic [3:0]  col_bias_q;
    logic [3:0]  col_prech_q;
    logic [6:0]  tg_low_q;
    logic [6:0]  rst_low_q;
    logic [6:0]  prech_lvl_q;
    logic [6:0]  ref_lvl_q;
    logic [6:0]  ramp_a_q;
    logic [6:0]  ramp_b_q;
    offset_t     offset_q;
    amp_gain_e   amp_gain_q;
    logic [7:0]  slope_q;
    logic        cfg_a_q;
    logic        cfg_b_q;
    logic        clip_lo_q;
    logic        clip_hi_q;

    // bus side
    logic        ack_q;
    logic [31:0] dat_q;

    // pixel side
    logic [PIX_W-1:0] pix_q;
    logic             pix_valid_q;

    // address decode, index sits above the two byte bits
    wire logic [7:0] idx       = adr_i[9:2];
    wire logic       req       = cyc_i & stb_i & ~ack_q;
    wire logic       wr_stb    = req & we_i & sel_i[0] & ce_i;
    wire logic       hit_lane  = (idx == `IDX_LANE_EN);
    wire logic       hit_bias  = (idx == `IDX_COL_BIAS);
    wire logic       hit_cpre  = (idx == `IDX_COL_PRECH);
    wire logic       hit_tg    = (idx == `IDX_TG_LOW);
    wire logic       hit_rlow  = (idx == `IDX_RST_LOW);
    wire logic       hit_plvl  = (idx == `IDX_PRECH_LVL);
    wire logic       hit_ref   = (idx == `IDX_REF_LVL);
    wire logic       hit_rampa = (idx == `IDX_RAMP_A);
    wire logic       hit_rampb = (idx == `IDX_RAMP_B);
    wire logic       hit_offlo = (idx == `IDX_OFFS_LO);
    wire logic       hit_offhi = (idx == `IDX_OFFS_HI);
    wire logic       hit_gain  = (idx == `IDX_AMP_GAIN);
    wire logic       hit_slope = (idx == `IDX_SLOPE);
    wire logic       hit_cfgb  = (idx == `IDX_CFG_B);
    wire logic       hit_cfga  = (idx == `IDX_CFG_A);
    wire logic       hit_stat  = (idx == `IDX_STATUS);
    wire logic       hit_dark  = (idx == `IDX_DARK_LVL);

    // per-register write strobes; every field sits in byte lane 0
    wire logic       we_lane   = wr_stb & hit_lane;
    wire logic       we_bias   = wr_stb & hit_bias;
    wire logic       we_cpre   = wr_stb & hit_cpre;
    wire logic       we_tg     = wr_stb & hit_tg;
    wire logic       we_rlow   = wr_stb & hit_rlow;
    wire logic       we_plvl   = wr_stb & hit_plvl;
    wire logic       we_ref    = wr_stb & hit_ref;
    wire logic       we_rampa  = wr_stb & hit_rampa;
    wire logic       we_rampb  = wr_stb & hit_rampb;
    wire logic       we_offlo  = wr_stb & hit_offlo;
    wire logic       we_offhi  = wr_stb & hit_offhi;
    wire logic       we_gain   = wr_stb & hit_gain;
    wire logic       we_slope  = wr_stb & hit_slope;
    wire logic       we_cfgb   = wr_stb & hit_cfgb;
    wire logic       we_cfga   = wr_stb & hit_cfga;

    // signed dark level seen with a zero raw code
    wire pix_sum_t dark_lvl = `ADC_FIXED_OFFS
                            + pix_sum_t'(offset_q);          // RULE1 RULE2

    // the host is relied on to keep both ramp levels equal; flag it
    wire logic ramp_mismatch = (ramp_a_q != ramp_b_q);      // RULE9

    // corrected code: raw + fixed offset + signed field, then clamp
    wire pix_sum_t pix_sum = pix_sum_t'({1'b0, pix_i})
                           + dark_lvl;                      // RULE2
    wire logic     under   = (pix_sum < 18'sh00000);        // RULE14
    wire logic     over    = (pix_sum > PIX_MAX);           // RULE14
    wire logic [PIX_W-1:0] pix_clamped =
        under ? '0 :
        over  ? PIX_MAX[PIX_W-1:0] :
                pix_sum[PIX_W-1:0];                         // RULE14

    // status and sticky clip flags; software clears with a one
    wire logic clr_lo = wr_stb & hit_stat & dat_i[`ST_CLIP_LO];
    wire logic clr_hi = wr_stb & hit_stat & dat_i[`ST_CLIP_HI];
    wire logic set_lo = ce_i & pix_valid_i & under;
    wire logic set_hi = ce_i & pix_valid_i & over;

    // next flag values; a clip in the clearing cycle survives
    wire logic clip_lo_d = set_lo | (clip_lo_q & ~clr_lo);  // RULE14
    wire logic clip_hi_d = set_hi | (clip_hi_q & ~clr_hi);  // RULE14

    // read-only words; the dark level reads back sign-extended
    wire logic [31:0] status_w = {29'h0, ramp_mismatch, clip_hi_q, clip_lo_q};
    wire logic [31:0] dark_w   = {{14{dark_lvl[17]}}, dark_lvl};

    // read selection; unmapped indices read as zero
    wire logic [31:0] rd_mux =
        hit_lane  ? {29'h0, lane_en_q}                        :
        hit_bias  ? {28'h0, col_bias_q}                       :
        hit_cpre  ? {28'h0, col_prech_q}                      :
        hit_tg    ? {25'h0, tg_low_q}                         :
        hit_rlow  ? {25'h0, rst_low_q}                        :
        hit_plvl  ? {25'h0, prech_lvl_q}                      :
        hit_ref   ? {25'h0, ref_lvl_q}                        :
        hit_rampa ? {25'h0, ramp_a_q}                         :
        hit_rampb ? {25'h0, ramp_b_q}                         :
        hit_offlo ? {24'h0, offset_q[7:0]}                    :
        hit_offhi ? {26'h0, offset_q[13:8]}                   :
        hit_gain  ? {30'h0, amp_gain_q}                       :
        hit_slope ? {24'h0, slope_q}                          :
        hit_cfgb  ? {31'h0, cfg_b_q}                          :
        hit_cfga  ? {31'h0, cfg_a_q}                          :
        hit_stat  ? status_w                                  :
        hit_dark  ? dark_w                                    :
                    32'h0;

    // single-wait-state answer; every index answers, so no bus hangs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else if (ce_i) begin
            ack_q <= req;
            dat_q <= (req & ~we_i) ? rd_mux : 32'h0;
        end
    end

    // required bias values are loaded by the host after start-up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lane_en_q   <= `RST_LANE_EN;
            col_bias_q  <= `RST_COL_BIAS;
            col_prech_q <= `RST_COL_PRECH;
        end else begin
            if (we_lane) begin
                lane_en_q <= dat_i[2:0];                    // RULE8
            end
            if (we_bias) begin
                col_bias_q <= dat_i[3:0];                   // RULE8
            end
            if (we_cpre) begin
                col_prech_q <= dat_i[3:0];                  // RULE8
            end
        end
    end

    // analog levels; reset values only hold until the host reloads them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tg_low_q    <= `RST_LEVEL7;
            rst_low_q   <= `RST_LEVEL7;
            prech_lvl_q <= `RST_LEVEL7;
            ref_lvl_q   <= `RST_LEVEL7;
        end else begin
            if (we_tg) begin
                tg_low_q <= dat_i[6:0];                     // RULE8
            end
            if (we_rlow) begin
                rst_low_q <= dat_i[6:0];                    // RULE8
            end
            if (we_plvl) begin
                prech_lvl_q <= dat_i[6:0];                  // RULE8
            end
            if (we_ref) begin
                ref_lvl_q <= dat_i[6:0];                    // RULE8
            end
        end
    end

    // ramp start levels are two registers; nothing forces them equal
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_a_q <= `RST_RAMP;
            ramp_b_q <= `RST_RAMP;
        end else begin
            if (we_rampa) begin
                ramp_a_q <= dat_i[6:0];
            end
            if (we_rampb) begin
                ramp_b_q <= dat_i[6:0];
            end
        end
    end

    // offset halves update at once, so a two-write change shows a
    // short intermediate value on the pixel path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            offset_q <= `RST_OFFSET;                        // RULE3
        end else begin
            if (we_offlo) begin
                offset_q[7:0] <= dat_i[`OFFS_LO_W-1:0];     // RULE3
            end
            if (we_offhi) begin
                offset_q[13:8] <= dat_i[`OFFS_HI_W-1:0];    // RULE3
            end
        end
    end

    // gain controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_gain_q <= amp_gain_e'(`RST_AMP_GAIN);       // RULE4
            slope_q    <= `RST_SLOPE;                       // RULE5
        end else begin
            if (we_gain) begin
                amp_gain_q <= amp_gain_e'(dat_i[1:0]);      // RULE4
            end
            if (we_slope) begin
                slope_q <= dat_i[7:0];                      // RULE5
            end
        end
    end

    // configuration bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_a_q <= `RST_CFG;
            cfg_b_q <= `RST_CFG;
        end else begin
            if (we_cfga) begin
                cfg_a_q <= dat_i[0];                        // RULE8
            end
            if (we_cfgb) begin
                cfg_b_q <= dat_i[0];                        // RULE8
            end
        end
    end

    // sticky clip flags: a clip in the clearing cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clip_lo_q <= 1'b0;
            clip_hi_q <= 1'b0;
        end else if (ce_i) begin
            clip_lo_q <= clip_lo_d;                         // RULE14
            clip_hi_q <= clip_hi_d;                         // RULE14
        end
    end

    // corrected pixel stage, one cycle of latency
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pix_q       <= '0;
            pix_valid_q <= 1'b0;
        end else if (ce_i) begin
            pix_valid_q <= pix_valid_i;
            if (pix_valid_i) begin
                pix_q <= pix_clamped;                       // RULE14
            end
        end
    end

    // bus outputs
    assign ack_o       = ack_q;
    assign dat_o       = dat_q;

    // pixel outputs
    assign pix_o       = pix_q;
    assign pix_valid_o = pix_valid_q;

    // analog controls; the slope code is passed raw because its real
    // gain depends on the master clock rate, which is not known here
    assign lane_en_o   = lane_en_q;
    assign col_bias_o  = col_bias_q;
    assign col_prech_o = col_prech_q;
    assign tg_low_o    = tg_low_q;
    assign rst_low_o   = rst_low_q;
    assign prech_lvl_o = prech_lvl_q;
    assign ref_lvl_o   = ref_lvl_q;
    assign ramp_a_o    = ramp_a_q;
    assign ramp_b_o    = ramp_b_q;
    assign amp_gain_o  = amp_gain_q;                        // RULE4
    assign slope_o     = slope_q;                           // RULE6
    assign cfg_a_o     = cfg_a_q;
    assign cfg_b_o     = cfg_b_q;

endmodule // sensor_offset_gain_config

`default_nettype wire

// file: sim/sensor_cfg_sva.sv
// port checker for the offset and gain configuration bank
// assumes one clock clk_i and synchronous active-high reset rst_i
`timescale 1ns/100ps
`default_nettype none
`include "sensor_cfg_defs.svh"

module sensor_cfg_sva #(
    parameter int PIX_W = 10                     // output code width
) (
    input wire logic             clk_i,          // clock
    input wire logic             rst_i,          // sync reset
    input wire logic             ce_i,           // clock enable
    input wire logic             cyc_i,          // bus cycle
    input wire logic             stb_i,          // bus strobe
    input wire logic             we_i,           // write enable
    input wire logic [9:0]       adr_i,          // byte address
    input wire logic [3:0]       sel_i,          // byte lanes
    input wire logic [31:0]      dat_i,          // write data
    input wire logic [31:0]      dat_o,          // read data
    input wire logic             ack_o,          // acknowledge
    input wire logic             pix_valid_i,    // raw code valid
    input wire logic [PIX_W-1:0] pix_o,          // corrected code
    input wire logic             pix_valid_o,    // corrected valid
    input wire logic [6:0]       ramp_a_o,       // ramp level a
    input wire logic [1:0]       amp_gain_o,     // gain code
    input wire logic [7:0]       slope_o         // ramp slope
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // request decode; writes with lane 0 off must not store
    wire take_w  = cyc_i && stb_i && !ack_o && ce_i;
    wire wr_w    = take_w && we_i && sel_i[0];
    wire slope_w = wr_w && (adr_i[9:2] == `IDX_SLOPE);
    wire gain_w  = wr_w && (adr_i[9:2] == `IDX_AMP_GAIN);

    a_ack_answer: assert property (take_w |=> ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
        else $error("acknowledge longer than one cycle");
    a_idle_data: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data not zero outside answer");
    a_pix_follow: assert property (ce_i |=> pix_valid_o == $past(pix_valid_i))
        else $error("pixel valid not delayed by one");
    a_pix_hold: assert property (ce_i && !pix_valid_i |=> $stable(pix_o))
        else $error("pixel output moved without input");
    a_reset_vals: assert property ($past(rst_i) |->
        amp_gain_o == 2'h0 && slope_o == 8'h20 && ramp_a_o == 7'h60)
        else $error("wrong value after reset");
    a_slope_write: assert property (
        slope_w |=> slope_o == $past(dat_i[7:0]))
        else $error("slope write lost");
    a_gain_write: assert property (
        gain_w |=> amp_gain_o == $past(dat_i[1:0]))
        else $error("gain write lost");
    a_slope_hold: assert property (!slope_w |=> $stable(slope_o))
        else $error("slope changed without write");

    c_slope: cover property (slope_w);
    c_gain: cover property (gain_w);
    c_clip: cover property (pix_valid_o && pix_o == '1);
endmodule // sensor_cfg_sva

bind sensor_offset_gain_config sensor_cfg_sva #(.PIX_W(PIX_W)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pix_valid_i(pix_valid_i), .pix_o(pix_o), .pix_valid_o(pix_valid_o),
    .ramp_a_o(ramp_a_o), .amp_gain_o(amp_gain_o), .slope_o(slope_o));
`default_nettype wire

// file: sim/host_cfg_model.sv
// host camera controller model: classic wishbone master
// assumes the slave answers within 64 cycles
`timescale 1ns/100ps
`default_nettype none

module host_cfg_model (
    input  wire logic        clk_i,    // bus clock
    input  wire logic        ack_i,    // slave acknowledge
    input  wire logic [31:0] dat_i,    // read data
    output logic             cyc_o,    // cycle
    output logic             stb_o,    // strobe
    output logic             we_o,     // write enable
    output logic [9:0]       adr_o,    // byte address
    output logic [3:0]       sel_o,    // byte lanes
    output logic [31:0]      dat_o     // write data
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 10'h000;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // one transfer; request held until ack is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [3:0] sel, inout logic [31:0] d,
                        output logic ok);
        ok = 1'b0;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {idx, 2'b00};
        sel_o <= sel;
        dat_o <= d;
        for (int n = 0; n < 64 && !ok; n++) begin
            @(posedge clk_i);
            ok = ack_i;
        end
        if (!w) d = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= ~w;
        adr_o <= ~{idx, 2'b00};
        dat_o <= ~d; // stale data never left on the bus
    endtask

    // start-up load, ramp pair equal and tuned in range
    task automatic load_required(output logic ok);
        logic [7:0]  ix [12] = '{8'h52, 8'h54, 8'h55, 8'h58, 8'h5b, 8'h5e,
                                 8'h5f, 8'h73, 8'h75, 8'h62, 8'h63, 8'h67};
        logic [31:0] v  [12] = '{32'h7, 32'h4, 32'h1, 32'h40, 32'h40,
                                 32'h65, 32'h6a, 32'h1, 32'h1, 32'h6c,
                                 32'h6c, 32'h30};
        logic        k;
        ok = 1'b1;
        for (int i = 0; i < 12; i++) begin
            xfer(1'b1, ix[i], 4'hf, v[i], k);
            ok = ok & k;
        end
    endtask
endmodule // host_cfg_model
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the offset and gain configuration bank
// assumes the host model owns the bus and this bench the pixel stream
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
    err_count++; $display("[ERR] %0t got %h want %h", $time, a, e); end end

module tb import sensor_cfg_pkg::*;;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce  = 1'b1;    // dropped only in the frozen-cycle test
    logic        pv  = 1'b0;
    logic [9:0]  px  = 10'h000;
    int          err_count = 0;
    int          check_count = 0;
    logic        ok;
    wire         cyc, stb, we, ack, pvo, cfa, cfb;
    wire  [9:0]  adr, pxo;
    wire  [3:0]  sel, cb, cp;
    wire  [31:0] wd, rd;
    wire  [2:0]  ln;
    wire  [6:0]  tg, rl, pl, rf, ra, rb;
    wire  [1:0]  gn;
    wire  [7:0]  sl;
    // offset, dark level, raw pixel, expected pixel
    logic [31:0] ot [4] = '{32'h1fff, 32'h2000, 32'h0, 32'h3fff};
    logic [31:0] dk [4] = '{32'h2045, 32'hffffe046, 32'h46, 32'h45};
    logic [9:0]  rw [4] = '{10'h0, 10'h3ff, 10'h3b9, 10'h0};
    logic [9:0]  ex [4] = '{10'h3ff, 10'h0, 10'h3ff, 10'h45};
    logic [7:0]  ix [15] = '{8'h52, 8'h54, 8'h55, 8'h58, 8'h5b, 8'h5e, 8'h5f,
        8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h73, 8'h75};
    logic [31:0] rv [15] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h60, 32'h60, 32'hc3, 32'h3f, 32'h0, 32'h20, 32'h0, 32'h0};
    logic [31:0] mk [15] = '{32'h7, 32'hf, 32'hf, 32'h7f, 32'h7f, 32'h7f,
        32'h7f, 32'h7f, 32'h7f, 32'hff, 32'h3f, 32'h3, 32'hff, 32'h1, 32'h1};

    always #10 clk = ~clk;

    sensor_offset_gain_config #(.PIX_W(10)) u_dut (
        .clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd),
        .ack_o(ack), .pix_i(px), .pix_valid_i(pv), .pix_o(pxo),
        .pix_valid_o(pvo), .lane_en_o(ln), .col_bias_o(cb),
        .col_prech_o(cp), .tg_low_o(tg), .rst_low_o(rl), .prech_lvl_o(pl),
        .ref_lvl_o(rf), .ramp_a_o(ra), .ramp_b_o(rb), .amp_gain_o(gn),
        .slope_o(sl), .cfg_a_o(cfa), .cfg_b_o(cfb));

    host_cfg_model u_host (.clk_i(clk), .ack_i(ack), .dat_i(rd),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
        .dat_o(wd));

    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // a lost acknowledge ends the run at once
    task automatic wr(input logic [7:0] i, input logic [31:0] d,
                      input logic [3:0] s = 4'hf);
        u_host.xfer(1'b1, i, s, d, ok);
        if (!ok) begin
            err_count++;
            complete_run();
        end
    endtask

    task automatic rdc(input logic [7:0] i, input logic [31:0] e);
        logic [31:0] d = 32'h0;
        u_host.xfer(1'b0, i, 4'hf, d, ok);
        `CHK({ok, d}, {1'b1, e})
        if (!ok) begin
            complete_run();
        end
    endtask

    task automatic pix(input logic [9:0] r, input logic [9:0] e);
        @(posedge clk);
        px <= r;
        pv <= 1'b1;
        @(posedge clk);
        pv <= 1'b0;
        #1;
        `CHK({pvo, pxo}, {1'b1, e})
    endtask

    initial begin
        #1000000;
        err_count++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 15; k++) begin
            rdc(ix[k], rv[k]);
            wr(ix[k], 32'hffffffff);
            rdc(ix[k], mk[k]);
        end
        $display("test table done");
        // second reset mid-run; slope and dark level must read back their defaults
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h67, 32'h20);
        rdc(8'h79, 32'h9);
        pix(10'h0, 10'h9);
        for (int k = 0; k < 4; k++) begin
            wr(8'h64, ot[k] & 32'hff);
            wr(8'h65, ot[k] >> 8);
            rdc(8'h79, dk[k]);
            pix(rw[k], ex[k]);
        end
        rdc(8'h78, 32'h3);
        wr(8'h78, 32'h3);
        rdc(8'h78, 32'h0);
        wr(8'h63, 32'h61);
        rdc(8'h78, 32'h4);
        $display("test offset done");
        for (int g = 0; g < 4; g++) begin
            wr(8'h66, g);
            rdc(8'h66, g);
            `CHK(gn, amp_gain_e'(g))
        end
        wr(8'h67, 32'h55, 4'he);
        rdc(8'h67, 32'h20);
        wr(8'h10, 32'hffffffff);
        rdc(8'h10, 32'h0);
        // frozen cycles: a valid pixel must leave no trace
        @(posedge clk);
        ce <= 1'b0;
        px <= 10'h100;
        pv <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK({pvo, pxo}, {1'b0, 10'h045})
        ce <= 1'b1;
        pv <= 1'b0;
        $display("test gain done");
        u_host.load_required(ok);
        `CHK({ok, ln, cb, cp}, {1'b1, 3'h7, 4'h4, 4'h1})
        `CHK({tg, rl, pl, rf}, {7'h40, 7'h40, 7'h65, 7'h6a})
        `CHK({ra, rb, sl, cfa, cfb}, {7'h6c, 7'h6c, 8'h30, 2'h3})
        if (!ok) begin
            complete_run();
        end
        wr(8'h67, 32'h37);
        rdc(8'h67, 32'h37);
        wr(8'h64, 32'hc3);
        rdc(8'h79, 32'h9);
        $display("test load done");
        complete_run();
    end
endmodule // tb
`default_nettype wire
